//--- hcs_sequencer.sv
`include "hcs_consts.svh"
module hcs_sequencer (
	input  wire logic                   clk_sys,
	input  wire logic                   sys_rst,
	input  wire logic                   jaw_close_in,
	input  wire logic                   heat_start_in,
	input  wire logic                   manual_heat_key,
	input  wire logic                   enter_key,
	input  wire logic                   menu_at_cal,
	input  wire logic                   home_view,
	input  wire logic                   alarm_shown,
	input  wire logic                   alarm_ack,
	input  wire logic                   cal_block_fault,
	input  wire logic                   band_cooling_fast,
	input  wire logic [9:0]             set_point,
	input  wire logic [9:0]             actual_temp,
	input  wire logic [5:0]             ambient_ref_in,
	input  wire logic [1:0]             temp_range,
	input  wire logic [4:0]             foot_hold_ds,
	input  wire logic                   timing_holds_relay,
	input  wire logic                   seal_phase_end,
	input  wire logic                   single_mode,
	input  wire hcs_pkg::hcs_hold_mode_t hold_mode,
	output logic                        load_relay,
	output logic                        heat_band1,
	output logic                        heat_band2,
	output logic                        timing_launch,
	output logic                        heat_refused,
	output logic                        cal_running,
	output logic [3:0]                  cal_countdown,
	output logic [5:0]                  cal_ambient,
	output logic                        msg_band_hot,
	output logic                        msg_cal_locked,
	output logic                        hold_time_alarm,
	output logic [11:0]                 temp_out_code,
	output logic [9:0]                  disp_temp,
	output logic                        hold_indicator,
	output logic [29:0]                 cycle_count
);
	timeunit 1ns;
	timeprecision 1ns;
	import hcs_pkg::*;

	logic tick_ms, jaw_s, start_s;
	hcs_tick u_tick (.clk_sys(clk_sys), .sys_rst(sys_rst), .tick_ms(tick_ms));
	hcs_sync u_sync_jaw (.clk_sys(clk_sys), .sys_rst(sys_rst), .din(jaw_close_in),
		.dout(jaw_s));
	hcs_sync u_sync_start (.clk_sys(clk_sys), .sys_rst(sys_rst), .din(heat_start_in),
		.dout(start_s));

	// Previous values for edge detection
	logic jaw_prev_q, start_prev_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			jaw_prev_q   <= 1'b0;
			start_prev_q <= 1'b0;
		end else begin
			jaw_prev_q   <= jaw_s;
			start_prev_q <= start_s;
		end
	end
	wire jaw_rise   = jaw_s & ~jaw_prev_q;
	wire jaw_fall   = ~jaw_s & jaw_prev_q;
	wire start_rise = start_s & ~start_prev_q;
	wire start_fall = ~start_s & start_prev_q;

	// Calibration sequence
	hcs_cal_state_t cal_q, cal_d;
	logic [3:0]     cnt_q;
	logic [9:0]     cal_ms_q;
	logic [5:0]     amb_q;
	wire cal_req   = menu_at_cal & enter_key;
	wire cal_ok    = ~band_cooling_fast & ~start_s & ~cal_block_fault;
	wire cal_go    = (cal_q == HCS_CAL_IDLE) & cal_req & cal_ok;
	wire cal_sec   = tick_ms & (cal_ms_q == `HCS_CAL_STEP_MS - 10'd1);
	wire cal_done  = (cal_q == HCS_CAL_RUN) & cal_sec & (cnt_q == 4'h0);
	wire cal_on    = (cal_q == HCS_CAL_RUN);
	always_comb begin
		case (cal_q)
			HCS_CAL_IDLE: cal_d = cal_go ? HCS_CAL_RUN : HCS_CAL_IDLE;
			HCS_CAL_RUN:  cal_d = cal_done ? HCS_CAL_IDLE : HCS_CAL_RUN;
			default:      cal_d = HCS_CAL_IDLE;
		endcase
	end
	// Countdown steps once per second from 14, giving about 15 s in all
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cal_q    <= HCS_CAL_IDLE;
			cnt_q    <= 4'h0;
			cal_ms_q <= 10'h0;
		end else begin
			cal_q    <= cal_d;
			cnt_q    <= cal_go ? `HCS_CAL_COUNT : (cal_sec && cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q;
			cal_ms_q <= cal_go ? 10'h0 : !tick_ms ? cal_ms_q : cal_sec ? 10'h0 : cal_ms_q + 10'h1;
		end
	end
	// Ambient reference clamped to 0..40, taken only when idle
	wire [5:0] amb_clamp = (ambient_ref_in > 6'(`HCS_AMB_MAX)) ? 6'(`HCS_AMB_MAX) : ambient_ref_in;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) amb_q <= 6'd20;
		else if (!cal_on) amb_q <= amb_clamp;
	end
	assign cal_running    = cal_on;
	assign cal_countdown  = cal_on ? cnt_q : 4'h0;
	assign cal_ambient    = amb_q;
	assign msg_band_hot   = menu_at_cal & band_cooling_fast;
	assign msg_cal_locked = menu_at_cal & start_s;

	// 200 ms lockouts after jaw and start release
	logic [7:0] jaw_lock_q, start_lock_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			jaw_lock_q   <= 8'h0;
			start_lock_q <= 8'h0;
		end else begin
			jaw_lock_q   <= jaw_fall ? `HCS_LOCKOUT_MS :
				(tick_ms && jaw_lock_q != 8'h0) ? jaw_lock_q - 8'h1 : jaw_lock_q;
			start_lock_q <= start_fall ? `HCS_LOCKOUT_MS :
				(tick_ms && start_lock_q != 8'h0) ? start_lock_q - 8'h1 : start_lock_q;
		end
	end
	wire jaw_locked   = (jaw_lock_q != 8'h0);
	wire start_locked = (start_lock_q != 8'h0);

	// Jaw input acceptance; a held contact stays refused until re-pressed
	logic jaw_act_q;
	wire  jaw_block = cal_on | alarm_shown;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) jaw_act_q <= 1'b0;
		else if (!jaw_s || jaw_block) jaw_act_q <= 1'b0;
		else if (jaw_rise && !jaw_locked) jaw_act_q <= 1'b1;
	end

	// Foot hold timer, in 100 ms steps up to 2.0 s
	logic [11:0] fh_q;
	logic        fh_wait_q;
	wire  [11:0] fh_load = 12'(foot_hold_ds) * 12'd100;
	wire  [11:0] fh_clip = (fh_load > `HCS_FOOT_HOLD_MAX) ? `HCS_FOOT_HOLD_MAX : fh_load;
	wire         jaw_take = jaw_rise & ~jaw_locked & ~jaw_block;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) fh_q <= 12'h0;
		else if (jaw_take) fh_q <= fh_clip;
		else if (jaw_block) fh_q <= 12'h0;
		else if (tick_ms && fh_q != 12'h0) fh_q <= fh_q - 12'h1;
	end
	// Start must arrive before the hold expires
	always_ff @(posedge clk_sys) begin
		if (sys_rst) fh_wait_q <= 1'b0;
		else if (jaw_take) fh_wait_q <= (fh_clip != 12'h0);
		else if (start_s) fh_wait_q <= 1'b0;
		else if (fh_q == 12'h0) fh_wait_q <= 1'b0;
	end
	logic alarm_q;
	wire  fh_expire = fh_wait_q & ~start_s & (fh_q == 12'h0);
	always_ff @(posedge clk_sys) begin
		if (sys_rst) alarm_q <= 1'b0;
		else if (fh_expire) alarm_q <= 1'b1;
		else if (alarm_ack) alarm_q <= 1'b0;
	end
	assign hold_time_alarm = alarm_q;

	// Start trigger: edge, outside lockout, not in calibration
	wire start_take = start_rise & ~start_locked & ~cal_on;
	wire set_ok     = (set_point > `HCS_MIN_HEAT_SET);
	wire manual_heat_key_take  = manual_heat_key & home_view & ~cal_on;
	logic launch_q, refuse_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			launch_q <= 1'b0;
			refuse_q <= 1'b0;
		end else begin
			launch_q <= start_take & set_ok;
			refuse_q <= (start_take | (manual_heat_key & home_view)) & ~set_ok;
		end
	end
	assign timing_launch = launch_q;
	assign heat_refused  = refuse_q;

	// Relay and band drive; a running hold overrides the release lockout, or it could never hold
	logic relay_q, band1_q, band2_q;
	wire  relay_d = (jaw_act_q & ~jaw_locked) | (fh_q != 12'h0) | timing_holds_relay;
	wire  heat_d  = manual_heat_key_take & set_ok & ~cal_on;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			relay_q <= 1'b0;
			band1_q <= 1'b0;
			band2_q <= 1'b0;
		end else begin
			relay_q <= relay_d & ~cal_on;
			band1_q <= heat_d;
			band2_q <= heat_d & ~single_mode;
		end
	end
	assign load_relay = relay_q;
	assign heat_band1 = band1_q;
	assign heat_band2 = band2_q;

	// Cycle counter
	logic [29:0] cyc_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst || enter_key) cyc_q <= 30'h0;
		else if (start_take) cyc_q <= (cyc_q == `HCS_CYCLE_MAX) ? 30'h0 : cyc_q + 30'h1;
	end
	assign cycle_count = cyc_q;

	// Output scaling; 200 uses 300 scale, 400 uses 500 scale
	wire        big_scale = temp_range[1];
	wire [9:0]  scale_top = big_scale ? `HCS_SCALE_500 : `HCS_SCALE_300;
	wire [9:0]  t_clip    = (actual_temp > scale_top) ? scale_top : actual_temp;
	wire [21:0] t_prod    = 22'(t_clip) * 22'(`HCS_DAC_FULL);
	wire [11:0] t_code    = 12'(t_prod / 22'(scale_top));
	logic [11:0] out_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) out_q <= 12'h0;
		else out_q <= cal_on ? 12'h0 : t_code;
	end
	assign temp_out_code = out_q;

	// Display hold: latch at phase end; live after reset, or after alarm ack in HCS_HOLD_ON and after 2 s in HCS_HOLD_2S
	logic [9:0]  held_q;
	logic        have_q;
	logic [11:0] h2_q;
	logic [6:0]  blank_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			held_q <= 10'h0;
			have_q <= 1'b0;
			h2_q   <= 12'h0;
		end else begin
			if (seal_phase_end) held_q <= actual_temp;
			have_q <= seal_phase_end | (have_q & ~alarm_ack);
			h2_q   <= seal_phase_end ? `HCS_HOLD2S_MS :
				(tick_ms && h2_q != 12'h0) ? h2_q - 12'h1 : h2_q;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) blank_q <= 7'h0;
		else if (seal_phase_end) blank_q <= `HCS_HOLD_BLANK_MS;
		else if (tick_ms && blank_q != 7'h0) blank_q <= blank_q - 7'h1;
	end
	wire showing_held = (hold_mode == HCS_HOLD_ON) ? have_q :
		(hold_mode == HCS_HOLD_2S) ? (h2_q != 12'h0) : 1'b0;
	logic [9:0] disp_q;
	logic       ind_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			disp_q <= 10'h0;
			ind_q  <= 1'b0;
		end else begin
			disp_q <= showing_held ? held_q : actual_temp;
			ind_q  <= showing_held & (blank_q == 7'h0);
		end
	end
	assign disp_temp      = disp_q;
	assign hold_indicator = ind_q;

	// Checks
	cal_out_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cal_on |=> temp_out_code == 12'h0) else $error("output not zero in cal");
	cal_no_heat_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$past(cal_on) |-> !heat_band1 && !heat_band2) else $error("heat during cal");
	low_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!set_ok && $stable(set_point) |=> !heat_band1 && !timing_launch) else $error("low set heat");
	jaw_lock_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		jaw_fall && !timing_holds_relay && fh_q == 12'h0 ##1 !timing_holds_relay
		|=> !load_relay) else $error("relay on in lockout");
	single_band_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$past(single_mode) |-> !heat_band2) else $error("band2 in single");
	cal_refuse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cal_q == HCS_CAL_IDLE && (band_cooling_fast || start_s || cal_block_fault)
		|=> !cal_running) else $error("cal not refused");
	start_cal_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cal_on |=> !timing_launch) else $error("start in cal");
	cycle_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		enter_key |=> cycle_count == 30'h0) else $error("counter not cleared");
	hold_alarm_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		fh_expire && !alarm_ack |=> hold_time_alarm) else $error("no hold alarm");
	cal_run_c: cover property (@(posedge clk_sys) cal_go ##1 cal_on);
	launch_c: cover property (@(posedge clk_sys) timing_launch);
	hold_c: cover property (@(posedge clk_sys) hold_indicator);
endmodule

//--- hcs_consts.svh
`ifndef HCS_CONSTS_SVH
`define HCS_CONSTS_SVH
// Clock and tick
`define HCS_CLK_HZ          10000000
`define HCS_TICK_MS_CYC     (`HCS_CLK_HZ / 1000)
// Temperatures in whole degrees C, range codes and the DAC full-scale code
`define HCS_MIN_HEAT_SET    10'd40
`define HCS_AMB_MAX         10'd40
`define HCS_RANGE_200       2'd0
`define HCS_RANGE_300       2'd1
`define HCS_RANGE_400       2'd2
`define HCS_RANGE_500       2'd3
`define HCS_SCALE_300       10'd300
`define HCS_SCALE_500       10'd500
`define HCS_DAC_FULL        12'hfff
// Intervals in ms, and the calibration step count
`define HCS_LOCKOUT_MS      8'd200
`define HCS_CAL_STEP_MS     10'd1000
`define HCS_CAL_COUNT       4'd14
`define HCS_HOLD2S_MS       12'd2000
`define HCS_HOLD_BLANK_MS   7'd100
`define HCS_FOOT_HOLD_MAX   12'd2000
// Counter
`define HCS_CYCLE_MAX       30'd999999999
`endif

//--- hcs_pkg.sv
package hcs_pkg;
	timeunit 1ns;
	timeprecision 1ns;
	typedef enum logic [1:0] {HCS_HOLD_OFF, HCS_HOLD_ON, HCS_HOLD_2S} hcs_hold_mode_t;
	typedef enum logic [1:0] {HCS_CAL_IDLE, HCS_CAL_RUN} hcs_cal_state_t;
endpackage

//--- hcs_sync.sv
`include "hcs_consts.svh"
// Three-stage synchroniser; a change is taken once stages one and two agree
module hcs_sync (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic din,
	output logic      dout
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] s_q;
	logic       o_q;
	wire        agree = (s_q[1] == s_q[2]);
	// Stage zero is read only by stage one
	always_ff @(posedge clk_sys) begin
		if (sys_rst) s_q <= 3'h0;
		else s_q <= {s_q[1:0], din};
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) o_q <= 1'b0;
		else if (agree) o_q <= s_q[2];
	end
	assign dout = o_q;
endmodule

//--- hcs_tick.sv
`include "hcs_consts.svh"
// Millisecond tick from the system clock
module hcs_tick (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	output logic      tick_ms
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [13:0] LAST = 14'(`HCS_TICK_MS_CYC - 1);
	logic [13:0] cnt_q;
	wire         wrap = (cnt_q == LAST);
	always_ff @(posedge clk_sys) begin
		if (sys_rst || wrap) cnt_q <= 14'h0;
		else cnt_q <= cnt_q + 14'h1;
	end
	assign tick_ms = wrap;
	tick_period_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tick_ms |=> !tick_ms) else $error("tick too frequent");
endmodule

//--- hcs_machine.sv
// Machine side: jaw and start contacts, moved only just after clock edges
module hcs_machine (
	input  wire logic clk_sys,
	input  wire logic jaw_cmd,
	input  wire logic start_cmd,
	input  wire logic load_relay,
	output logic      jaw_close_in,
	output logic      heat_start_in,
	output logic      relay_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		jaw_close_in = 1'b0;
		heat_start_in = 1'b0;
		relay_seen = 1'b0;
	end
	// Contacts are levels; a new start close always follows an open, never a double close
	always @(posedge clk_sys) begin
		jaw_close_in <= jaw_cmd;
		heat_start_in <= start_cmd;
		relay_seen <= load_relay;
	end
endmodule

//--- test_heatseal_cycle_sequencer.sv
module test_heatseal_cycle_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	import hcs_pkg::*;
	logic clk_sys = 1'b0, sys_rst = 1'b1, jaw_cmd = 1'b0, start_cmd = 1'b0;
	logic jaw_close_in, heat_start_in, relay_seen;
	logic manual_heat_key = 1'b0, enter_key = 1'b0, menu_at_cal = 1'b0, home_view = 1'b1;
	logic alarm_shown = 1'b0, alarm_ack = 1'b0, cal_block_fault = 1'b0, band_cooling_fast = 1'b0;
	logic [9:0] set_point = 10'h064, actual_temp = 10'h000;
	logic [5:0] ambient_ref_in = 6'h19;
	logic [1:0] temp_range = 2'h1;
	logic [4:0] foot_hold_ds = 5'h00;
	logic timing_holds_relay = 1'b0, seal_phase_end = 1'b0, single_mode = 1'b0;
	hcs_hold_mode_t hold_mode = HCS_HOLD_OFF;
	logic load_relay, heat_band1, heat_band2, timing_launch, heat_refused, cal_running;
	logic msg_band_hot, msg_cal_locked, hold_time_alarm, hold_indicator;
	logic [3:0] cal_countdown;
	logic [5:0] cal_ambient;
	logic [11:0] temp_out_code;
	logic [9:0] disp_temp;
	logic [29:0] cycle_count;
	int mismatches = 0, tests_run = 0, cycles = 0, launches = 0, refusals = 0, n0, r0;
	hcs_machine i_hcs_machine (.clk_sys(clk_sys), .jaw_cmd(jaw_cmd), .start_cmd(start_cmd),
		.load_relay(load_relay), .jaw_close_in(jaw_close_in), .heat_start_in(heat_start_in),
		.relay_seen(relay_seen));
	hcs_sequencer i_hcs_sequencer (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.jaw_close_in(jaw_close_in), .heat_start_in(heat_start_in),
		.manual_heat_key(manual_heat_key), .enter_key(enter_key), .menu_at_cal(menu_at_cal),
		.home_view(home_view), .alarm_shown(alarm_shown), .alarm_ack(alarm_ack),
		.cal_block_fault(cal_block_fault), .band_cooling_fast(band_cooling_fast),
		.set_point(set_point), .actual_temp(actual_temp), .ambient_ref_in(ambient_ref_in),
		.temp_range(temp_range), .foot_hold_ds(foot_hold_ds),
		.timing_holds_relay(timing_holds_relay), .seal_phase_end(seal_phase_end),
		.single_mode(single_mode), .hold_mode(hold_mode), .load_relay(load_relay),
		.heat_band1(heat_band1), .heat_band2(heat_band2), .timing_launch(timing_launch),
		.heat_refused(heat_refused), .cal_running(cal_running), .cal_countdown(cal_countdown),
		.cal_ambient(cal_ambient), .msg_band_hot(msg_band_hot), .msg_cal_locked(msg_cal_locked),
		.hold_time_alarm(hold_time_alarm), .temp_out_code(temp_out_code),
		.disp_temp(disp_temp), .hold_indicator(hold_indicator), .cycle_count(cycle_count));
	// 100 ns period
	always #50 clk_sys = ~clk_sys;
	task automatic final_report();
		$display("tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Launch pulses and start refusals last one cycle, so they are counted here rather than sampled by the tests
	always @(posedge clk_sys) begin
		cycles++;
		if (timing_launch === 1'b1) launches++;
		if (heat_refused === 1'b1) refusals++;
		if (cycles == 60000) begin
			mismatches++;
			final_report();
		end
	end
	// Wait n edges, then let that edge's updates settle before sampling
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask
	// Rounding of the output scaling is left open, so allow two codes either way
	task automatic near(input logic [11:0] got, input int exp, input string msg);
		tests_run++;
		if (((got + 3 > exp) && (got < exp + 3)) !== 1'b1) begin
			mismatches++;
			$display("wrong value at %0t: %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask
	// Reset also clears the 200 ms lockouts, which would outlast the whole run
	task automatic do_reset();
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		cyc(2);
	endtask
	task automatic pulse_enter();
		@(posedge clk_sys);
		enter_key <= 1'b1;
		@(posedge clk_sys);
		enter_key <= 1'b0;
		cyc(3);
	endtask
	initial begin
		do_reset();
		check(cycle_count, 0, "count after reset");
		// Output scaling over every range code, including the clip above the top
		for (int r = 0; r < 4; r++) begin
			for (int t = 0; t < 3; t++) begin
				@(posedge clk_sys);
				temp_range <= r[1:0];
				actual_temp <= 10'(t * 300);
				cyc(5);
				near(temp_out_code, (t == 2) ? 4095 : t * 300 * 4095 / ((r < 2) ? 300 : 500),
					"scale");
			end
		end
		@(posedge clk_sys);
		temp_range <= 2'h1;
		jaw_cmd <= 1'b1;
		cyc(10);
		check(load_relay, 1, "jaw relay on");
		check(relay_seen, 1, "relay at machine");
		@(posedge clk_sys);
		jaw_cmd <= 1'b0;
		cyc(10);
		check(load_relay, 0, "jaw relay off");
		@(posedge clk_sys);
		jaw_cmd <= 1'b1;
		cyc(20);
		check(load_relay, 0, "jaw lockout");
		// Short jaw press with a 100 ms hold
		jaw_cmd <= 1'b0;
		foot_hold_ds <= 5'h01;
		do_reset();
		jaw_cmd <= 1'b1;
		cyc(10);
		@(posedge clk_sys);
		jaw_cmd <= 1'b0;
		cyc(20);
		check(load_relay, 1, "hold time");
		check(hold_time_alarm, 0, "no alarm inside hold");
		foot_hold_ds <= 5'h00;
		do_reset();
		alarm_shown <= 1'b1;
		jaw_cmd <= 1'b1;
		cyc(20);
		check(load_relay, 0, "jaw in alarm");
		@(posedge clk_sys);
		alarm_shown <= 1'b0;
		cyc(20);
		check(load_relay, 0, "jaw needs re-press");
		jaw_cmd <= 1'b0;
		do_reset();
		// Start, release, quick re-press, counter clear
		n0 = launches;
		start_cmd <= 1'b1;
		cyc(10);
		check(launches - n0, 1, "launch");
		check(cycle_count, 1, "count start");
		@(posedge clk_sys);
		start_cmd <= 1'b0;
		cyc(10);
		@(posedge clk_sys);
		start_cmd <= 1'b1;
		cyc(10);
		check(launches - n0, 1, "start lockout");
		check(cycle_count, 1, "no count in lockout");
		check(load_relay, 0, "no relay in lockout");
		start_cmd <= 1'b0;
		pulse_enter();
		check(cycle_count, 0, "enter clears");
		// Low set point: no launch, no manual heat
		set_point <= 10'h028;
		do_reset();
		n0 = launches;
		r0 = refusals;
		start_cmd <= 1'b1;
		cyc(10);
		check(launches - n0, 0, "low set no launch");
		check(refusals > r0, 1, "refused pulse");
		check(cycle_count, 1, "low set counted");
		@(posedge clk_sys);
		start_cmd <= 1'b0;
		manual_heat_key <= 1'b1;
		cyc(5);
		check(heat_band1, 0, "low set manual");
		@(posedge clk_sys);
		set_point <= 10'h029;
		cyc(5);
		check({heat_band1, heat_band2}, 2'b11, "double manual heat");
		check(launches - n0, 0, "manual no launch");
		check(cycle_count, 1, "manual not counted");
		@(posedge clk_sys);
		single_mode <= 1'b1;
		cyc(3);
		check({heat_band1, heat_band2}, 2'b10, "single mode");
		@(posedge clk_sys);
		home_view <= 1'b0;
		cyc(3);
		check(heat_band1, 0, "manual outside home");
		manual_heat_key <= 1'b0;
		home_view <= 1'b1;
		single_mode <= 1'b0;
		// Calibration refusals, then a run
		set_point <= 10'h064;
		do_reset();
		ambient_ref_in <= 6'h32;
		actual_temp <= 10'h0fa;
		menu_at_cal <= 1'b1;
		band_cooling_fast <= 1'b1;
		pulse_enter();
		check(cal_ambient, 40, "ambient clamp");
		check({cal_running, msg_band_hot}, 2'b01, "cooling refusal");
		band_cooling_fast <= 1'b0;
		cal_block_fault <= 1'b1;
		pulse_enter();
		check(cal_running, 0, "fault refusal");
		cal_block_fault <= 1'b0;
		pulse_enter();
		check(cal_running, 1, "cal start");
		check(cal_countdown, 14, "countdown");
		check(temp_out_code, 0, "output zero in cal");
		n0 = launches;
		start_cmd <= 1'b1;
		manual_heat_key <= 1'b1;
		jaw_cmd <= 1'b1;
		cyc(10);
		check(launches - n0, 0, "start in cal");
		check(heat_band1, 0, "no heat in cal");
		check(load_relay, 0, "jaw in cal");
		manual_heat_key <= 1'b0;
		jaw_cmd <= 1'b0;
		do_reset();
		// The held start contact needs its synchroniser delay before it can lock
		cyc(10);
		pulse_enter();
		check({cal_running, msg_cal_locked}, 2'b01, "start locks cal");
		start_cmd <= 1'b0;
		menu_at_cal <= 1'b0;
		hold_mode <= HCS_HOLD_ON;
		actual_temp <= 10'h07b;
		do_reset();
		@(posedge clk_sys);
		seal_phase_end <= 1'b1;
		@(posedge clk_sys);
		seal_phase_end <= 1'b0;
		cyc(3);
		@(posedge clk_sys);
		actual_temp <= 10'h0c8;
		cyc(5);
		check(disp_temp, 123, "held reading");
		check(hold_indicator, 0, "indicator blank");
		near(temp_out_code, 200 * 4095 / 300, "output live");
		@(posedge clk_sys);
		hold_mode <= HCS_HOLD_OFF;
		cyc(5);
		check(disp_temp, 200, "live reading");
		// Two second mode: reading freezes at phase end, indicator starts blanked
		@(posedge clk_sys);
		hold_mode <= HCS_HOLD_2S;
		seal_phase_end <= 1'b1;
		@(posedge clk_sys);
		seal_phase_end <= 1'b0;
		actual_temp <= 10'h096;
		cyc(5);
		check(disp_temp, 200, "two second hold");
		check(hold_indicator, 0, "indicator blank 2s");
		final_report();
	end
endmodule
